// ===== hdl/sbst_tap.sv
// test access port controller, instruction, bypass and identify registers
`timescale 1ns/100ps
module sbst_tap
    import sbst_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic [BSR_W-1:0] ring,
    output logic                  tdo,
    output logic                  tdo_oe,
    output logic                  mem_hiz
);

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    // all three pins take the same two stages, so tms and tdi stay lined up
    // with the test clock edge that is detected from the second stage
    logic        tck_s1_r;
    logic        tck_s2_r;
    logic        tck_d_r;
    logic        tms_s1_r;
    logic        tms_s2_r;
    logic        tdi_s1_r;
    logic        tdi_s2_r;

    always_ff @(posedge clock) begin
        tck_s1_r <= tck;
        tck_s2_r <= tck_s1_r;
        tms_s1_r <= tms;
        tms_s2_r <= tms_s1_r;
        tdi_s1_r <= tdi;
        tdi_s2_r <= tdi_s1_r;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tck_d_r <= 1'h0;
        end else begin
            tck_d_r <= tck_s2_r;
        end
    end

    wire tck_rise = tck_s2_r & ~tck_d_r;  // see RQ2
    wire tck_fall = ~tck_s2_r & tck_d_r;

    // ------------------------------------------------------------------------
    // controller state machine
    // ------------------------------------------------------------------------
    sbst_state_e st_r;
    sbst_state_e st_nxt;
    sbst_state_e st_step;

    always_comb begin
        st_step = st_r;
        unique case (st_r)
            S_TLR:    st_step = tms_s2_r ? S_TLR    : S_RTI;  // see RQ23
            S_RTI:    st_step = tms_s2_r ? S_SEL_DR : S_RTI;
            S_SEL_DR: st_step = tms_s2_r ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: st_step = tms_s2_r ? S_EX1_DR : S_SH_DR;
            S_SH_DR:  st_step = tms_s2_r ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: st_step = tms_s2_r ? S_UPD_DR : S_PA_DR;
            S_PA_DR:  st_step = tms_s2_r ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: st_step = tms_s2_r ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: st_step = tms_s2_r ? S_SEL_DR : S_RTI;
            S_SEL_IR: st_step = tms_s2_r ? S_TLR    : S_CAP_IR;
            S_CAP_IR: st_step = tms_s2_r ? S_EX1_IR : S_SH_IR;
            S_SH_IR:  st_step = tms_s2_r ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: st_step = tms_s2_r ? S_UPD_IR : S_PA_IR;
            S_PA_IR:  st_step = tms_s2_r ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: st_step = tms_s2_r ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: st_step = tms_s2_r ? S_SEL_DR : S_RTI;
        endcase
    end

    assign st_nxt = tck_rise ? st_step : st_r;  // see RQ25

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= S_TLR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // state decode
    // ------------------------------------------------------------------------
    // register actions are taken on the rising edge that leaves the state,
    // with tdi sampled on that same edge
    wire in_shift  = (st_r == S_SH_DR) | (st_r == S_SH_IR);
    wire cap_ir    = tck_rise & (st_r == S_CAP_IR);
    wire sh_ir     = tck_rise & (st_r == S_SH_IR);
    wire upd_ir    = tck_rise & (st_r == S_UPD_IR);
    wire cap_dr    = tck_rise & (st_r == S_CAP_DR);
    wire sh_dr     = tck_rise & (st_r == S_SH_DR);

    // ------------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------------
    logic [IR_W-1:0] ir_sh_r;
    logic [IR_W-1:0] ir_sh_nxt;
    logic [IR_W-1:0] ir_r;
    logic [IR_W-1:0] ir_nxt;

    assign ir_sh_nxt = cap_ir ? IR_CAPTURE :                           // see RQ6
                       sh_ir  ? {tdi_s2_r, ir_sh_r[IR_W-1:1]} :        // see RQ4
                       ir_sh_r;
    // reserved codes are accepted as written and fall through to bypass
    assign ir_nxt = (st_r == S_TLR) ? IR_IDCODE :                      // see RQ5
                    upd_ir          ? ir_sh_r   : ir_r;                // see RQ12

    always_ff @(posedge clock) begin
        if (srst) begin
            ir_sh_r <= IR_CAPTURE;
            ir_r    <= IR_IDCODE;
        end else begin
            ir_sh_r <= ir_sh_nxt;
            ir_r    <= ir_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------------------
    wire is_extest  = (ir_r == IR_EXTEST);   // see RQ21
    wire is_idcode  = (ir_r == IR_IDCODE);
    wire is_samplez = (ir_r == IR_SAMPLEZ);
    wire is_sample  = (ir_r == IR_SAMPLE);   // see RQ22
    wire sel_bsr    = is_extest | is_samplez | is_sample;
    wire sel_byp    = ~sel_bsr & ~is_idcode;  // see RQ17

    // the only effect on the memory is the output tri-state
    assign mem_hiz = is_extest | is_samplez;  // see RQ13 see RQ14 see RQ18

    // ------------------------------------------------------------------------
    // bypass and identify registers
    // ------------------------------------------------------------------------
    logic            byp_r;
    logic            byp_nxt;
    logic [ID_W-1:0] id_r;
    logic [ID_W-1:0] id_nxt;

    assign byp_nxt = (cap_dr & sel_byp) ? BYP_RESET :                 // see RQ8
                     (sh_dr & sel_byp)  ? tdi_s2_r  : byp_r;          // see RQ7
    assign id_nxt  = (cap_dr & is_idcode) ? ID_CODE :                  // see RQ11 see RQ24
                     (sh_dr & is_idcode)  ? {tdi_s2_r, id_r[ID_W-1:1]} : id_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            byp_r <= BYP_RESET;
            id_r  <= '0;
        end else begin
            byp_r <= byp_nxt;
            id_r  <= id_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // boundary scan register
    // ------------------------------------------------------------------------
    logic bsr_lsb;

    // sample and both hiz codes capture alike; update-dr is not decoded
    sbst_bsr u_bsr (
        .clock   (clock),
        .srst    (srst),
        .ring    (ring),
        .capture (cap_dr & sel_bsr),   // see RQ15
        .shift   (sh_dr & sel_bsr),
        .tdi     (tdi_s2_r),
        .lsb     (bsr_lsb)
    );

    // ------------------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------------------
    logic tdo_r;
    logic tdo_nxt;
    logic tdo_oe_r;
    logic tdo_oe_nxt;

    wire dr_bit  = is_idcode ? id_r[0] : sel_bsr ? bsr_lsb : byp_r;   // see RQ1
    wire sel_bit = (st_r == S_SH_IR) ? ir_sh_r[0] : dr_bit;           // see RQ10

    assign tdo_nxt    = tck_fall ? sel_bit : tdo_r;                    // see RQ3
    assign tdo_oe_nxt = tck_fall ? in_shift : tdo_oe_r;                // see RQ26

    always_ff @(posedge clock) begin
        if (srst) begin
            tdo_r    <= 1'h0;
            tdo_oe_r <= 1'h0;
        end else begin
            tdo_r    <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
        end
    end

    assign tdo    = tdo_r;
    assign tdo_oe = tdo_oe_r;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // consecutive tms-high rising edges, saturating
    logic [2:0] tms_cnt_r;
    wire        tms_cnt_full = (tms_cnt_r == 3'(RST_CNT));

    always_ff @(posedge clock) begin
        if (srst) begin
            tms_cnt_r <= 3'h0;
        end else if (tck_rise) begin
            tms_cnt_r <= !tms_s2_r ? 3'h0 : tms_cnt_full ? tms_cnt_r : tms_cnt_r + 3'h1;
        end
    end

    sequence s_ir_update;
        tck_rise && st_r == S_UPD_IR;
    endsequence

    sequence s_id_capture;
        tck_rise && st_r == S_CAP_DR && ir_r == IR_IDCODE;
    endsequence

    tdo_fall_only_a: assert property ($changed(tdo_r) |-> $past(tck_fall)) // see RQ3
        else $error("tdo moved without a falling test clock");

    ir_reset_load_a: assert property (st_r == S_TLR |=> ir_r == IR_IDCODE) // see RQ5
        else $error("reset state did not load identify");

    ir_capture_a: assert property (cap_ir |=> ir_sh_r[1:0] == 2'b01) // see RQ6
        else $error("capture-ir pattern wrong");

    ir_update_only_a: assert property ( // see RQ12
        $changed(ir_r) |-> $past(st_r == S_UPD_IR || st_r == S_TLR))
        else $error("instruction changed outside update-ir");

    ir_apply_a: assert property (s_ir_update ##1 1 |-> ir_r == $past(ir_sh_r)) // see RQ12
        else $error("update-ir did not apply shifted code");

    byp_clear_a: assert property ( // see RQ8
        tck_rise && st_r == S_CAP_DR && ir_r == IR_BYPASS |=> byp_r == 1'b0)
        else $error("bypass not cleared at capture");

    id_capture_a: assert property (s_id_capture |=> id_r == ID_CODE && id_r[0]) // see RQ11
        else $error("identify code not captured");

    tap_reset_a: assert property (tms_cnt_full |-> st_r == S_TLR) // see RQ23
        else $error("five tms-high edges did not reset");

    oe_shift_a: assert property (tck_fall |=> tdo_oe_r == $past(in_shift)) // see RQ26
        else $error("tdo enable wrong for state");

    byp_path_a: assert property ( // see RQ17
        tck_fall && st_r == S_SH_DR && ir_r == IR_BYPASS |=> tdo_r == $past(byp_r))
        else $error("bypass bit not on tdo");

    hiz_decode_a: assert property ( // see RQ14
        s_ir_update ##0 (ir_sh_r == IR_SAMPLEZ || ir_sh_r == IR_EXTEST) |=> mem_hiz)
        else $error("hiz code did not tri-state memory");

    sample_free_a: assert property (ir_r == IR_SAMPLE |-> !mem_hiz) // see RQ15
        else $error("sample disturbed memory outputs");

endmodule : sbst_tap

// ===== shared/sbst_pkg.sv
// package: constants, codes and state type of the memory boundary-scan test port
// ----------------------------------------------------------------------------
// What this block does
// RQ1 - exactly one scan register between tdi and tdo
// RQ2 - tdi sampled on every rising test clock
// RQ3 - tdo changes only on falling test clock
// RQ4 - three-bit instruction register, shifted when selected
// RQ5 - identify instruction loaded at reset and idle-reset
// RQ6 - capture-ir loads 01 into low bits
// RQ7 - one-bit bypass register gives single-stage path
// RQ8 - bypass register cleared under bypass instruction
// RQ9 - boundary register captures ring, then shifts
// RQ10 - msb takes tdi, lsb drives tdo
// RQ11 - identify loads fixed 32-bit code, shifts out
// RQ12 - new instruction applied only at update-ir
// RQ13 - code 000 captures ring, outputs high impedance
// RQ14 - sample-hiz shifts boundary register, outputs high impedance
// RQ15 - sample captures ring without disturbing memory
// RQ16 - update-dr under sample does nothing at all
// RQ17 - bypass instruction selects bypass bit in shift-dr
// RQ18 - never loads memory or drives boundary values
// RQ19 - controller never loads the reserved codes
// RQ20 - controller keeps test clock at most 20 MHz
// RQ21 - codes 000, 001, 010 decode as listed
// RQ22 - code 100 sample, 111 bypass, rest reserved
// RQ23 - five tms-high rising edges reset the port
// RQ24 - identify code bit 0 is constant one
// RQ25 - standard sixteen-state controller, tms picks transitions
// RQ26 - tdo driven only in shift-ir or shift-dr
// ----------------------------------------------------------------------------
package sbst_pkg;

    // ------------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------------
    localparam int IR_W   = 3;
    localparam int ID_W   = 32;
    localparam int BSR_W  = 71;
    localparam int RST_CNT = 5;

    // ------------------------------------------------------------------------
    // instruction codes and reset values
    // ------------------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
    localparam logic [IR_W-1:0] IR_IDCODE  = 3'h1;
    localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h4;
    localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    localparam logic            BYP_RESET  = 1'h0;

    // identify code fields; value is arbitrary, bit 0 must stay one
    localparam logic [2:0]  ID_REV    = 3'h0;
    localparam logic [27:0] ID_PART   = 28'h5a3c96b;
    localparam logic        ID_MARK   = 1'h1;
    localparam logic [ID_W-1:0] ID_CODE = {ID_REV, ID_PART, ID_MARK};

    // ------------------------------------------------------------------------
    // timing: test clock limit, in the bench clock units
    // ------------------------------------------------------------------------
    localparam int CLK_NS      = 8;
    localparam int TCK_MIN_NS  = 50;
    localparam int TCK_MIN_CYC = (TCK_MIN_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [3:0] {
        S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR,
        S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
    } sbst_state_e;

endpackage : sbst_pkg

// ===== hdl/sbst_bsr.sv
// boundary scan register: synchronised ring snapshot and serial shift path
`timescale 1ns/100ps
module sbst_bsr
    import sbst_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic [BSR_W-1:0] ring,
    input  wire logic             capture,
    input  wire logic             shift,
    input  wire logic             tdi,
    output logic                  lsb
);

    // ------------------------------------------------------------------------
    // ring synchroniser
    // ------------------------------------------------------------------------
    // balls move with the fast memory clock, so a capture mid-transition
    // may land either way; only metastability is kept out here
    logic [BSR_W-1:0] ring_s1_r;
    logic [BSR_W-1:0] ring_s2_r;
    logic [BSR_W-1:0] bsr_r;
    logic [BSR_W-1:0] bsr_nxt;

    always_ff @(posedge clock) begin
        ring_s1_r <= ring;
        ring_s2_r <= ring_s1_r;
    end

    // ------------------------------------------------------------------------
    // capture and shift
    // ------------------------------------------------------------------------
    assign bsr_nxt = capture ? ring_s2_r :                       // see RQ9
                     shift   ? {tdi, bsr_r[BSR_W-1:1]} : bsr_r;  // see RQ10

    always_ff @(posedge clock) begin
        if (srst) begin
            bsr_r <= '0;
        end else begin
            bsr_r <= bsr_nxt;
        end
    end

    // no parallel output stage: nothing here can reach the pins
    assign lsb = bsr_r[0];  // see RQ16

endmodule : sbst_bsr

// ===== sim/sbst_jtag_ctl.sv
// partner model: board-level test controller driving test clock, mode and data
`timescale 1ns/100ps
module sbst_jtag_ctl
    import sbst_pkg::*;
(
    input  wire logic clock,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    // ------------------------------------------------------------------------
    // pins and one test clock period
    // ------------------------------------------------------------------------
    // pulled-up pins idle high; test clock stands low between frames
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h1;
    end

    // 10 system clocks a period, 80 ns, slower than 20 MHz
    // mode and data set at the fall, half a period before the rise
    // tdo read just before the rise, after the fall has moved it
    task automatic step(input logic m, input logic d, output logic o, output logic oe);
        tms <= m;
        tdi <= d;
        repeat (5) @(posedge clock);
        o   = tdo_oe ? tdo : ~tdo;  // released pin reads as junk, not stale data
        oe  = tdo_oe;
        tck <= 1'h1;
        repeat (5) @(posedge clock);
        tck <= 1'h0;
    endtask : step

    // ------------------------------------------------------------------------
    // walks through the state machine
    // ------------------------------------------------------------------------
    // five mode-high rises from any state, then on to idle
    task automatic reset_port;
        logic o;
        logic oe;
        repeat (5) step(1'h1, 1'h1, o, oe);
        step(1'h0, 1'h1, o, oe);
    endtask : reset_port

    // idle -> capture -> shift n bits, lsb first -> update -> idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout, output logic ok);
        logic o;
        logic oe;
        dout = '0;
        ok   = 1'h1;
        step(1'h1, 1'h1, o, oe);
        if (ir) step(1'h1, 1'h1, o, oe);
        step(1'h0, 1'h1, o, oe);
        step(1'h0, 1'h1, o, oe);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o, oe);
            dout[i] = o;
            if (oe !== 1'h1) ok = 1'h0;
        end
        step(1'h1, 1'h1, o, oe);
        if (oe !== 1'h0) ok = 1'h0;
        step(1'h0, 1'h1, o, oe);
    endtask : scan
endmodule : sbst_jtag_ctl

// ===== sim/sram_boundary_scan_tap_tb.sv
// testbench: test port driven through its instructions by the controller model
`timescale 1ns/100ps
`define CHK(nm, want, got) begin \
    comparisons++; \
    if ((got) !== (want)) begin \
        failures++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, want, got); \
    end \
end
module sram_boundary_scan_tap_tb
    import sbst_pkg::*;
;
    // ------------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------------
    localparam logic [127:0] DIN  = 128'h3c5a_96e1_0f7b_d248_a5c3_1e69_7d82_b4f0;
    localparam logic [127:0] RPAT = 128'h5e3c_96a1_7b2d_48f0_c3a5_1e69_d278_b40f;

    logic             clock;
    logic             srst;
    logic [BSR_W-1:0] ring;
    logic             tck;
    logic             tms;
    logic             tdi;
    logic             tdo;
    logic             tdo_oe;
    logic             mem_hiz;
    int               failures    = 0;
    int               comparisons = 0;

    sbst_tap uut (.clock(clock), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
                  .ring(ring), .tdo(tdo), .tdo_oe(tdo_oe), .mem_hiz(mem_hiz));

    sbst_jtag_ctl ctl (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe),
                       .tck(tck), .tms(tms), .tdi(tdi));

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic conclude;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // shifts the code in over a 6-bit frame; the first 3 out are the capture
    task automatic load(input logic [IR_W-1:0] code);
        logic [127:0] dout;
        logic         ok;
        ctl.scan(1'h1, 6, {122'h0, code, 3'h5}, dout, ok);
        `CHK("ir capture", {3'h5, IR_CAPTURE}, dout[5:0])
    endtask : load

    task automatic t_reset_ident;
        logic [127:0] dout;
        logic [127:0] want;
        logic         ok;
        ctl.reset_port();
        `CHK("hiz after reset", 1'h0, mem_hiz)
        ctl.scan(1'h0, 40, DIN, dout, ok);
        want = (DIN << ID_W) | 128'(ID_CODE);
        `CHK("ident after reset", want[39:0], dout[39:0])
        `CHK("ident presence bit", 1'h1, dout[0])
        `CHK("tdo enable in shift", 1'h1, ok)
        `CHK("tdo enable in idle", 1'h0, tdo_oe)
    endtask : t_reset_ident

    // only the five listed codes are loaded
    task automatic t_codes;
        logic [IR_W-1:0] codes [5] = '{IR_EXTEST, IR_IDCODE, IR_SAMPLEZ, IR_SAMPLE, IR_BYPASS};
        logic [127:0]    dout;
        logic [127:0]    want;
        logic [127:0]    cap;
        logic            ok;
        logic            hiz;
        int              len;
        for (int k = 0; k < 5; k++) begin
            ring <= BSR_W'(RPAT >> (k * 7));
            load(codes[k]);
            hiz = (codes[k] == IR_EXTEST) || (codes[k] == IR_SAMPLEZ);
            `CHK("output hiz", hiz, mem_hiz)
            len = (codes[k] == IR_BYPASS) ? 1 : (codes[k] == IR_IDCODE) ? ID_W : BSR_W;
            cap = (codes[k] == IR_BYPASS) ? '0 :
                  (codes[k] == IR_IDCODE) ? 128'(ID_CODE) : 128'(ring);
            ctl.scan(1'h0, 80, DIN ^ 128'(k), dout, ok);
            want = ((DIN ^ 128'(k)) << len) | cap;
            `CHK("data path", want[79:0], dout[79:0])
            `CHK("hiz after update", hiz, mem_hiz)
            `CHK("shift enable", 1'h1, ok)
        end
    endtask : t_codes

    // abort mid-shift by mode-high rises, then a system reset mid-run
    task automatic t_port_reset;
        logic         o;
        logic         oe;
        logic [127:0] dout;
        logic         ok;
        load(IR_EXTEST);
        ctl.step(1'h1, 1'h1, o, oe);
        ctl.step(1'h0, 1'h1, o, oe);
        ctl.step(1'h0, 1'h1, o, oe);
        ctl.step(1'h0, 1'h0, o, oe);
        t_reset_ident();
        load(IR_BYPASS);
        // bypass still holds a one from the earlier scan, so capture must clear it
        ctl.scan(1'h0, 8, DIN, dout, ok);
        `CHK("bypass cleared", {DIN[6:0], 1'h0}, dout[7:0])
        srst <= 1'h1;
        repeat (2) @(posedge clock);
        srst <= 1'h0;
        repeat (3) @(posedge clock);
        t_reset_ident();
    endtask : t_port_reset

    // ------------------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    // a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        conclude();
    end

    initial begin
        srst = 1'h1;
        ring = '0;
        repeat (20) @(posedge clock);
        srst <= 1'h0;
        repeat (3) @(posedge clock);
        t_reset_ident();
        t_codes();
        t_port_reset();
        conclude();
    end
endmodule : sram_boundary_scan_tap_tb
